// ---- hdl/fuch_regs.svh ----
// constants of the flash-update command handler: header offsets, field values,
// result codes and checksum parameters
// assumes byte offsets count from the first header byte of a frame
`ifndef FUCH_REGS_SVH
`define FUCH_REGS_SVH

`define FUCH_HDR_BYTES 7'h40
`define FUCH_OFS_PRE_HI 6'h00
`define FUCH_OFS_PRE_LO 6'h01
`define FUCH_OFS_REV 6'h02
`define FUCH_OFS_CMD 6'h03
`define FUCH_OFS_SUB 6'h04
`define FUCH_OFS_STATUS 6'h05
`define FUCH_OFS_LEN 6'h08
`define FUCH_OFS_DEST 6'h0C
`define FUCH_OFS_PCRC 6'h3A
`define FUCH_OFS_HCRC 6'h3E
`define FUCH_OFS_CRC_FIRST 6'h02
`define FUCH_OFS_CRC_LAST 6'h3D
`define FUCH_OFS_END 6'h3F

`define FUCH_PREAMBLE 16'hA1EC
`define FUCH_PROTO_REV 8'h03
`define FUCH_CMD_BOOT 8'h0B
`define FUCH_CMD_APP 8'h0C
`define FUCH_CMD_FILE 8'h0D
`define FUCH_SUB_SERIAL 8'h00
`define FUCH_SUB_PARALLEL 8'h01
`define FUCH_SUB_OTP 8'h02

`define FUCH_RES_OK 8'h00
`define FUCH_RES_TOO_BIG 8'hFA
`define FUCH_RES_HCRC_BAD 8'hFB
`define FUCH_RES_PCRC_BAD 8'hFC
`define FUCH_RES_LEN_ZERO 8'hFD
`define FUCH_RES_UNKNOWN 8'hFF

`define FUCH_CRC16_POLY 16'h1021
`define FUCH_CRC16_INIT 16'h0000
`define FUCH_CRC32_POLY 32'h04C11DB7
`define FUCH_CRC32_INIT 32'h0FFFFFFF

`define FUCH_MAX_FILE_BYTES 32'h00100000

`endif

// ---- hdl/fuch_pkg.sv ----
// types of the flash-update command handler
// assumes the constants header is included by the modules that need values
package fuch_pkg;
    // gray codes along hdr, chk, pay, fin, resp
    typedef enum logic [2:0] {
        ST_HDR = 3'h0,
        ST_CHK = 3'h1,
        ST_PAY = 3'h3,
        ST_FIN = 3'h2,
        ST_RESP = 3'h6
    } fuch_state_t;
endpackage

// ---- hdl/fuch_crc.sv ----
// one-byte step of a non-reflected crc, msb of the byte first
// assumes the caller holds the running value in its own register
module fuch_crc #(
    parameter int WIDTH = 16,
    parameter logic [WIDTH-1:0] POLY = '0
) (
    input wire logic [WIDTH-1:0] crc_in,
    input wire logic [7:0] data,
    output logic [WIDTH-1:0] crc_out
);
    // a register narrower than a byte cannot take a whole byte per step
    if (WIDTH < 8) begin : g_bad_width
        $error("fuch_crc needs WIDTH of at least 8");
    end

    // shift the byte through the register one bit at a time
    always_comb begin
        logic [WIDTH-1:0] c;
        c = crc_in;
        for (int i = 7; i >= 0; i--) begin
            if (c[WIDTH-1] ^ data[i]) begin
                c = {c[WIDTH-2:0], 1'b0} ^ POLY;
            end else begin
                c = {c[WIDTH-2:0], 1'b0};
            end
        end
        crc_out = c;
    end
endmodule

// ---- hdl/fuch_top.sv ----
// flash-update command handler: takes a command header and payload as a byte
// stream, writes the payload out to flash, and sends back a response header
// assumes rx and tx streams and the flash port run on CLK; no other command
// handlers share the stream
`include "fuch_regs.svh"

module fuch_top #(
    parameter logic [31:0] MAX_FILE_BYTES = `FUCH_MAX_FILE_BYTES
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic RX_VALID,
    input wire logic [7:0] RX_DATA,
    output logic RX_READY,
    output logic TX_VALID,
    output logic [7:0] TX_DATA,
    output logic TX_LAST,
    input wire logic TX_READY,
    output logic FL_WE,
    output logic [31:0] FL_ADDR,
    output logic [7:0] FL_DATA,
    output logic [7:0] FL_COMMAND,
    output logic [1:0] FL_TARGET,
    input wire logic FL_READY,
    output logic FL_COMMIT,
    output logic FL_ABORT
);
    // an empty download area could never accept any file
    if (MAX_FILE_BYTES == 32'h0) begin : g_bad_max
        $error("fuch_top needs MAX_FILE_BYTES above zero");
    end

    fuch_pkg::fuch_state_t state_q, state_d;
    logic [31:0] cnt_q;
    logic [15:0] pre_q;
    logic [7:0] rev_q, cmd_q, sub_q, status_q;
    logic [31:0] len_q, dest_q, pcrc_q;
    logic [15:0] hcrc_q;
    logic [15:0] rx_crc16_q, tx_crc16_q;
    logic [31:0] rx_crc32_q;
    logic fl_we_q;
    logic [31:0] fl_addr_q;
    logic [7:0] fl_data_q, tx_data_q;
    logic commit_q, abort_q;

    // handshake decode
    wire [5:0] hidx = cnt_q[5:0];
    wire rx_take = RX_VALID & RX_READY;
    wire hdr_take = rx_take & (state_q == fuch_pkg::ST_HDR);
    wire pay_take = rx_take & (state_q == fuch_pkg::ST_PAY);
    wire tx_take = TX_VALID & TX_READY;
    wire hdr_end = hdr_take & (hidx == `FUCH_OFS_END);
    wire pay_end = pay_take & (cnt_q == len_q - 32'h1);
    wire tx_end = tx_take & (hidx == `FUCH_OFS_END);
    wire flash_idle = ~fl_we_q | FL_READY;
    wire in_crc_span = (hidx >= `FUCH_OFS_CRC_FIRST) & (hidx <= `FUCH_OFS_CRC_LAST);

    wire rx_crc16_en = hdr_take & in_crc_span;
    wire tx_crc16_en = tx_take & in_crc_span;

    logic [15:0] rx_crc16_nx, tx_crc16_nx;
    logic [31:0] rx_crc32_nx;

    fuch_crc #(.WIDTH(16), .POLY(`FUCH_CRC16_POLY)) u_rx_crc16 (
        .crc_in(rx_crc16_q),
        .data(RX_DATA),
        .crc_out(rx_crc16_nx)
    );
    fuch_crc #(.WIDTH(16), .POLY(`FUCH_CRC16_POLY)) u_tx_crc16 (
        .crc_in(tx_crc16_q),
        .data(tx_data_q),
        .crc_out(tx_crc16_nx)
    );
    fuch_crc #(.WIDTH(32), .POLY(`FUCH_CRC32_POLY)) u_rx_crc32 (
        .crc_in(rx_crc32_q),
        .data(RX_DATA),
        .crc_out(rx_crc32_nx)
    );

    // header verdict, in order of precedence
    // marker check
    wire pre_ok = (pre_q == `FUCH_PREAMBLE);
    wire rev_ok = (rev_q == `FUCH_PROTO_REV);
    wire cmd_ok = (cmd_q == `FUCH_CMD_BOOT) | (cmd_q == `FUCH_CMD_APP) | (cmd_q == `FUCH_CMD_FILE);
    wire sub_ok = (sub_q == `FUCH_SUB_SERIAL) | (sub_q == `FUCH_SUB_PARALLEL) | (sub_q == `FUCH_SUB_OTP);
    wire hcrc_ok = (rx_crc16_q == hcrc_q);
    wire pcrc_ok = (rx_crc32_q == pcrc_q);
    // skip-crc flag ignored: no flags are captured at all
    wire [7:0] chk_status = ~hcrc_ok ? `FUCH_RES_HCRC_BAD :
                            ~(cmd_ok & sub_ok) ? `FUCH_RES_UNKNOWN :
                            (len_q == 32'h0) ? `FUCH_RES_LEN_ZERO :
                            (len_q > MAX_FILE_BYTES) ? `FUCH_RES_TOO_BIG : `FUCH_RES_OK;

    // response byte for a header index
    function automatic logic [7:0] resp_byte(input logic [5:0] idx, input logic [7:0] crc_byte,
                                             input logic [7:0] cmd, input logic [7:0] sub,
                                             input logic [7:0] st);
        logic [7:0] b;
        b = 8'h00;
        unique case (idx)
            `FUCH_OFS_PRE_HI: b = 8'(`FUCH_PREAMBLE >> 8);
            `FUCH_OFS_PRE_LO: b = 8'(`FUCH_PREAMBLE & 16'h00FF);
            `FUCH_OFS_REV: b = `FUCH_PROTO_REV;
            `FUCH_OFS_CMD: b = cmd;
            `FUCH_OFS_SUB: b = sub;
            `FUCH_OFS_STATUS: b = st;
            `FUCH_OFS_HCRC, `FUCH_OFS_END: b = crc_byte;
            default: b = 8'h00;
        endcase
        return b;
    endfunction

    // next response byte: the crc high byte must use the value updated by 0x3D
    wire [5:0] tx_next_idx = hidx + 6'h1;
    wire [7:0] tx_crc_byte = (tx_next_idx == `FUCH_OFS_HCRC) ? tx_crc16_nx[15:8] : tx_crc16_q[7:0];
    wire [7:0] tx_next_byte = resp_byte(tx_next_idx, tx_crc_byte, cmd_q, sub_q, status_q);
    wire [7:0] tx_first_byte = resp_byte(6'h00, 8'h00, cmd_q, sub_q, status_q);

    // generic file is placed at its destination, other images at zero
    wire [31:0] pay_base = (cmd_q == `FUCH_CMD_FILE) ? dest_q : 32'h0;

    // sequencer
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            fuch_pkg::ST_HDR: if (hdr_end) begin
                state_d = fuch_pkg::ST_CHK;
            end
            // bad marker or revision is dropped without an answer
            fuch_pkg::ST_CHK: if (~(pre_ok & rev_ok)) begin
                state_d = fuch_pkg::ST_HDR;
            end else if (chk_status == `FUCH_RES_OK) begin
                state_d = fuch_pkg::ST_PAY;
            end else begin
                state_d = fuch_pkg::ST_RESP;
            end
            // exactly length bytes of payload follow
            fuch_pkg::ST_PAY: if (pay_end) begin
                state_d = fuch_pkg::ST_FIN;
            end
            fuch_pkg::ST_FIN: if (flash_idle) begin
                state_d = fuch_pkg::ST_RESP;
            end
            fuch_pkg::ST_RESP: if (tx_end) begin
                state_d = fuch_pkg::ST_HDR;
            end
            default: state_d = fuch_pkg::ST_HDR;
        endcase
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            state_q <= fuch_pkg::ST_HDR;
        end else begin
            state_q <= state_d;
        end
    end

    // byte counter: header index, payload offset and response index share it
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            cnt_q <= 32'h0;
        end else if (state_q != state_d) begin
            cnt_q <= 32'h0;
        end else if (hdr_take | pay_take | tx_take) begin
            cnt_q <= cnt_q + 32'h1;
        end
    end

    // header field capture; multi-byte fields arrive high byte first
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            pre_q <= 16'h0;
            rev_q <= 8'h0;
            cmd_q <= 8'h0;
            sub_q <= 8'h0;
            len_q <= 32'h0;
            dest_q <= 32'h0;
            pcrc_q <= 32'h0;
            hcrc_q <= 16'h0;
        end else if (hdr_take) begin
            if (hidx <= `FUCH_OFS_PRE_LO) pre_q <= {pre_q[7:0], RX_DATA};
            if (hidx == `FUCH_OFS_REV) rev_q <= RX_DATA;
            if (hidx == `FUCH_OFS_CMD) cmd_q <= RX_DATA;
            if (hidx == `FUCH_OFS_SUB) sub_q <= RX_DATA;
            if (hidx[5:2] == `FUCH_OFS_LEN >> 2) len_q <= {len_q[23:0], RX_DATA};
            if (hidx[5:2] == `FUCH_OFS_DEST >> 2) dest_q <= {dest_q[23:0], RX_DATA};
            if (hidx >= `FUCH_OFS_PCRC && hidx < `FUCH_OFS_HCRC) pcrc_q <= {pcrc_q[23:0], RX_DATA};
            if (hidx >= `FUCH_OFS_HCRC) hcrc_q <= {hcrc_q[7:0], RX_DATA};
        end
    end

    // running checksums; the header crc restarts outside the header phase, the payload crc only during it
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            rx_crc16_q <= `FUCH_CRC16_INIT;
            rx_crc32_q <= `FUCH_CRC32_INIT;
        end else begin
            // a dropped header never reaches the response, so restart as soon as the header phase ends
            if (state_q != fuch_pkg::ST_HDR) rx_crc16_q <= `FUCH_CRC16_INIT;
            else if (rx_crc16_en) rx_crc16_q <= rx_crc16_nx;
            if (state_q == fuch_pkg::ST_HDR) rx_crc32_q <= `FUCH_CRC32_INIT;
            else if (pay_take) rx_crc32_q <= rx_crc32_nx;
        end
    end

    // flash write stage; holds a byte until the flash side takes it
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            fl_we_q <= 1'b0;
            fl_addr_q <= 32'h0;
            fl_data_q <= 8'h0;
        end else if (pay_take) begin
            fl_we_q <= 1'b1;
            fl_addr_q <= pay_base + cnt_q;
            fl_data_q <= RX_DATA;
        end else if (FL_READY) begin
            fl_we_q <= 1'b0;
        end
    end

    // result code and the end-of-image verdict pulses
    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            status_q <= `FUCH_RES_OK;
            commit_q <= 1'b0;
            abort_q <= 1'b0;
        end else begin
            commit_q <= 1'b0;
            abort_q <= 1'b0;
            if (state_q == fuch_pkg::ST_CHK) begin
                status_q <= chk_status;
            end
            // payload crc verdict once the last write has left
            if (state_q == fuch_pkg::ST_FIN && flash_idle) begin
                status_q <= pcrc_ok ? `FUCH_RES_OK : `FUCH_RES_PCRC_BAD;
                commit_q <= pcrc_ok;
                abort_q <= ~pcrc_ok;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RST_N) begin
            tx_data_q <= 8'h0;
            tx_crc16_q <= `FUCH_CRC16_INIT;
        end else if (state_q != fuch_pkg::ST_RESP) begin
            tx_data_q <= tx_first_byte;
            tx_crc16_q <= `FUCH_CRC16_INIT;
        end else if (tx_take) begin
            tx_data_q <= tx_next_byte;
            if (tx_crc16_en) tx_crc16_q <= tx_crc16_nx;
        end
    end

    // the first byte is reloaded while entering and is the fixed marker, so it does not depend on status
    wire [7:0] tx_shown = (cnt_q == 32'h0) ? tx_first_byte : tx_data_q;

    // payload is accepted only as fast as the flash stage drains
    assign RX_READY = (state_q == fuch_pkg::ST_HDR) | ((state_q == fuch_pkg::ST_PAY) & flash_idle);
    assign TX_VALID = (state_q == fuch_pkg::ST_RESP);
    assign TX_DATA = tx_shown;
    assign TX_LAST = TX_VALID & (hidx == `FUCH_OFS_END);
    assign FL_WE = fl_we_q;
    assign FL_ADDR = fl_addr_q;
    assign FL_DATA = fl_data_q;
    assign FL_COMMAND = cmd_q;
    assign FL_TARGET = sub_q[1:0];
    assign FL_COMMIT = commit_q;
    assign FL_ABORT = abort_q;
endmodule

// ---- test/fuch_flash_model.sv ----
// flash-side partner: takes write requests, stalling at random when told to
// assumes the handler holds each request until the ready edge
module fuch_flash_model (
    input wire logic clk,
    input wire logic slow,
    output logic ready
);
    timeunit 1ns;
    timeprecision 1ps;
    int seed = 30;
    // change only at the falling edge so a taken write is never cut short
    initial ready = 1'b1;
    always @(negedge clk) begin
        ready <= slow ? 1'($random(seed)) : 1'b1;
    end
endmodule

// ---- test/fuch_top_asserts.sv ----
// port checks of the flash-update handler
// assumes one clock and the synchronous active-low reset of the top
module fuch_asserts #(
    parameter logic [31:0] MAX_FILE_BYTES = 32'h00100000
) (
    input wire logic CLK,
    input wire logic RST_N,
    input wire logic RX_READY,
    input wire logic TX_VALID,
    input wire logic [7:0] TX_DATA,
    input wire logic TX_LAST,
    input wire logic TX_READY,
    input wire logic FL_WE,
    input wire logic [31:0] FL_ADDR,
    input wire logic [7:0] FL_DATA,
    input wire logic [7:0] FL_COMMAND,
    input wire logic [1:0] FL_TARGET,
    input wire logic FL_READY,
    input wire logic FL_COMMIT,
    input wire logic FL_ABORT
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    // stalled steps on the flash and response sides, and the response end
    sequence fl_stall_s; FL_WE && !FL_READY; endsequence
    sequence tx_stall_s; TX_VALID && !TX_READY; endsequence
    sequence tx_end_s; TX_VALID && TX_READY && TX_LAST; endsequence
    fl_hold_a: assert property (
        fl_stall_s |=> FL_WE && $stable(FL_ADDR) && $stable(FL_DATA)) else $error("flash write dropped");
    rx_stall_a: assert property (
        fl_stall_s |-> !RX_READY) else $error("byte taken while flash busy");
    tx_hold_a: assert property (
        tx_stall_s |=> TX_VALID && $stable(TX_DATA) && $stable(TX_LAST)) else $error("response byte lost");
    resp_mark_a: assert property (
        $rose(TX_VALID) |-> TX_DATA == 8'hA1) else $error("response lacks marker");
    done_resp_a: assert property (
        FL_COMMIT || FL_ABORT |-> $rose(TX_VALID) && !(FL_COMMIT && FL_ABORT)) else $error("bad image end");
    resp_end_a: assert property (
        tx_end_s |=> !TX_VALID && RX_READY) else $error("response overran");
    resp_quiet_a: assert property (
        TX_VALID |-> !RX_READY && !FL_WE) else $error("input open during response");
    fl_kind_a: assert property (
        FL_WE |-> FL_COMMAND inside {8'h0B, 8'h0C, 8'h0D} && FL_TARGET != 2'h3) else $error("bad write kind");
    pulse_one_a: assert property (
        FL_COMMIT || FL_ABORT |=> !FL_COMMIT && !FL_ABORT) else $error("end pulse too long");
    addr_bound_a: assert property (
        FL_WE && FL_COMMAND != 8'h0D |-> FL_ADDR < MAX_FILE_BYTES) else $error("image write beyond download area");
endmodule

bind fuch_top fuch_asserts #(.MAX_FILE_BYTES(MAX_FILE_BYTES)) u_chk (.CLK(CLK), .RST_N(RST_N),
    .RX_READY(RX_READY), .TX_VALID(TX_VALID), .TX_DATA(TX_DATA), .TX_LAST(TX_LAST), .TX_READY(TX_READY),
    .FL_WE(FL_WE), .FL_ADDR(FL_ADDR), .FL_DATA(FL_DATA), .FL_COMMAND(FL_COMMAND), .FL_TARGET(FL_TARGET),
    .FL_READY(FL_READY), .FL_COMMIT(FL_COMMIT), .FL_ABORT(FL_ABORT));

// ---- test/testbench.sv ----
// self-checking bench of the flash-update handler; the bench plays the host
// assumes the flash partner model and the port checker are compiled with it
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int MAXB = 16;
    logic clk, rst_n, rx_valid, rx_ready, tx_valid, tx_last, tx_ready;
    logic fl_we, fl_ready, fl_commit, fl_abort, slow;
    logic [7:0] rx_data, tx_data, fl_data, fl_command, cur_cmd, cur_sub;
    logic [31:0] fl_addr;
    logic [1:0] fl_target;
    logic [31:0] wa[$];
    logic [7:0] wd[$];
    int err_count, num_checks, seed, cm, ab;

    fuch_top #(.MAX_FILE_BYTES(32'h00000010)) u_dut (.CLK(clk), .RST_N(rst_n), .RX_VALID(rx_valid),
        .RX_DATA(rx_data), .RX_READY(rx_ready), .TX_VALID(tx_valid), .TX_DATA(tx_data), .TX_LAST(tx_last),
        .TX_READY(tx_ready), .FL_WE(fl_we), .FL_ADDR(fl_addr), .FL_DATA(fl_data), .FL_COMMAND(fl_command),
        .FL_TARGET(fl_target), .FL_READY(fl_ready), .FL_COMMIT(fl_commit), .FL_ABORT(fl_abort));
    fuch_flash_model u_flash (.clk(clk), .slow(slow), .ready(fl_ready));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task conclude();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // one msb-first crc step, ccitt when narrow
    function automatic logic [31:0] crc(input logic [31:0] c, input logic [7:0] d, input bit wide);
        for (int i = 7; i >= 0; i--) begin
            if (wide)
                c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? 32'h04C11DB7 : 32'h0);
            else
                c = {16'h0, c[14:0], 1'b0} ^ ((c[15] ^ d[i]) ? 32'h00001021 : 32'h0);
        end
        return c;
    endfunction

    // log writes the flash takes and the end-of-image pulses
    always @(posedge clk) begin
        if (rst_n && fl_we && fl_ready) begin
            wa.push_back(fl_addr);
            wd.push_back(fl_data);
            chk(fl_command, cur_cmd);
            chk(fl_target, cur_sub[1:0]);
        end
        cm += fl_commit;
        ab += fl_abort;
    end

    task put(input logic [7:0] b);
        int n;
        @(negedge clk);
        rx_valid = 1'b1;
        rx_data = b;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (!rx_ready && n < 200);
        if (n >= 200) begin
            err_count++;
            conclude();
        end
    endtask

    // sink stalls at random so every response byte must be held
    task get(input logic [7:0] e[64]);
        int i, n;
        i = 0;
        n = 0;
        while (i < 64 && n < 2000) begin
            @(negedge clk);
            tx_ready = 1'($random(seed));
            @(posedge clk);
            n++;
            if (tx_valid === 1'b1 && tx_ready) begin
                chk(tx_data, e[i]);
                chk(tx_last, i == 63);
                i++;
            end
        end
        if (i < 64) begin
            err_count++;
            conclude();
        end
        @(negedge clk);
        tx_ready = 1'b0;
    endtask

    task automatic run(input logic [7:0] cmd, sub, input int len, input logic [15:0] pre,
        input logic [7:0] rev, input bit hbad, pbad);
        logic [7:0] h[64];
        logic [7:0] e[64];
        logic [7:0] pay[$];
        logic [31:0] pc, hc, dest;
        logic [7:0] st;
        bit drop;
        int n;
        dest = $random(seed);
        pc = 32'h0FFFFFFF;
        hc = 0;
        cur_cmd = cmd;
        cur_sub = sub;
        wa.delete();
        wd.delete();
        cm = 0;
        ab = 0;
        // reserved and status bytes are don't-care, so fill them at random
        for (int i = 0; i < 64; i++) begin
            h[i] = $random(seed);
            e[i] = 8'h00;
        end
        {h[0], h[1], h[2], h[3], h[4], h[6], h[7]} = {pre, rev, cmd, sub, 16'h0000};
        {h[8], h[9], h[10], h[11], h[12], h[13], h[14], h[15]} = {32'(len), dest};
        drop = pre != 16'hA1EC || rev != 8'h03;
        st = drop || hbad ? 8'hFB : !(cmd inside {8'h0B, 8'h0C, 8'h0D}) || sub > 2 ? 8'hFF
            : len == 0 ? 8'hFD : len > MAXB ? 8'hFA : pbad ? 8'hFC : 8'h00;
        for (int i = 0; i < len; i++) begin
            pay.push_back($random(seed));
            pc = crc(pc, pay[i], 1);
        end
        {h[58], h[59], h[60], h[61]} = pc ^ 32'(pbad);
        for (int i = 2; i < 62; i++) hc = crc(hc, h[i], 0);
        {h[62], h[63]} = hc[15:0] ^ 16'(hbad);
        foreach (h[i]) put(h[i]);
        // payload follows only a header that was accepted, bad payload crc included
        if (st == 8'h00 || st == 8'hFC) foreach (pay[i]) put(pay[i]);
        @(negedge clk);
        rx_valid = 1'b0;
        if (drop) begin
            n = 0;
            repeat (100) @(posedge clk) n += tx_valid;
            chk(n, 0);
        end else begin
            {e[0], e[1], e[2], e[3], e[4], e[5]} = {16'hA1EC, 8'h03, cmd, sub, st};
            hc = 0;
            for (int i = 2; i < 62; i++) hc = crc(hc, e[i], 0);
            {e[62], e[63]} = hc[15:0];
            get(e);
        end
        chk(wa.size(), (st == 8'h00 || st == 8'hFC) ? len : 0);
        foreach (wa[i]) begin
            chk(wa[i], (cmd == 8'h0D ? dest : 32'h0) + i);
            chk(wd[i], pay[i]);
        end
        chk(cm, st == 8'h00);
        chk(ab, st == 8'hFC);
    endtask

    initial begin
        seed = 30;
        err_count = 0;
        num_checks = 0;
        slow = 1'b0;
        rst_n = 1'b0;
        rx_valid = 1'b0;
        rx_data = 8'h00;
        tx_ready = 1'b0;
        cur_cmd = 8'h00;
        cur_sub = 8'h00;
        repeat (6) @(negedge clk);
        rst_n = 1'b1;
        run(8'h0B, 8'h00, 1, 16'hA1EC, 8'h03, 0, 0);
        slow = 1'b1;
        for (int c = 0; c < 9; c++) begin
            run(8'h0B + 8'(c / 3), 8'(c % 3), 1 + {$random(seed)} % MAXB, 16'hA1EC, 8'h03, 0, 0);
        end
        run(8'h0D, 8'h02, MAXB, 16'hA1EC, 8'h03, 0, 0);
        run(8'h0C, 8'h01, MAXB + 1, 16'hA1EC, 8'h03, 0, 0);
        run(8'h0B, 8'h00, 0, 16'hA1EC, 8'h03, 0, 0);
        run(8'h0D, 8'h00, 4, 16'hA1EC, 8'h03, 1, 0);
        run(8'h07, 8'h00, 4, 16'hA1EC, 8'h03, 0, 0);
        run(8'h0C, 8'h03, 4, 16'hA1EC, 8'h03, 0, 0);
        run(8'h0D, 8'h01, 5, 16'hA1EC, 8'h03, 0, 1);
        run(8'h0B, 8'h00, 4, 16'hA1ED, 8'h03, 0, 0);
        run(8'h0B, 8'h00, 4, 16'hA1EC, 8'h02, 0, 0);
        run(8'h0C, 8'h00, 3, 16'hA1EC, 8'h03, 0, 0);
        conclude();
    end
endmodule
